// [hw/dcci_map.svh]
// Purpose: Register offsets, field positions and reset values
// Assumes: Byte addresses on a 32-bit register port
// Notes: Definitions only
`ifndef DCCI_MAP_SVH
`define DCCI_MAP_SVH
`define DCCI_CTRL 8'h00
`define DCCI_BOOT 8'h04
`define DCCI_STACK 8'h08
`define DCCI_PWR 8'h0c
`define DCCI_PRIO 8'h10
`define DCCI_BANKPWR 8'h14
`define DCCI_MB_TO_SEC 8'h18
`define DCCI_MB_TO_PRI 8'h1c
`define DCCI_MUTEX 8'h20
`define DCCI_STATUS 8'h24
`define DCCI_CTRL_HOLD 0
`define DCCI_CTRL_DIS 1
`define DCCI_PWR_LP 0
`define DCCI_ST_SLEEP 0
`define DCCI_ST_RUN 1
`define DCCI_ST_LPIGN 2
`define DCCI_ST_MLOCK 3
`define DCCI_ST_MOWN 4
`define DCCI_VEC_RST 32'h00000000
`define DCCI_SRC_PRI 1'b0
`endif

// [hw/dcci_pkg.sv]
// Purpose: Types of the dual core control block
// Assumes: Nothing
// Notes: Constants live in dcci_map.svh
package dcci_pkg;
    typedef enum logic [1:0] {SEC_HELD, SEC_SLEEP, SEC_RUN} dcci_sec_st_t;
    typedef enum logic [1:0] {BUS_ICODE, BUS_DCODE, BUS_SYS} dcci_bus_t;
endpackage

// [hw/dcci_top.sv]
// Purpose: Dual core control, bank arbitration, mailbox and mutex
// Assumes: One clock for both cores; core 0 is the faster core
// Notes: reg_src_in names the core making each register access
`include "dcci_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dcci_top #(
    parameter int NB = 4,
    parameter bit LATE_VARIANT = 1'b1,
    parameter int TW = 3
)(
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic reg_src_in,
    output logic [31:0] reg_rdata_out,
    input wire logic pri_req_in,
    input wire logic [1:0] pri_bus_in,
    input wire logic [TW-1:0] pri_tgt_in,
    input wire logic sec_req_in,
    input wire logic [TW-1:0] sec_tgt_in,
    output logic pri_gnt_out,
    output logic pri_stall_out,
    output logic pri_err_out,
    output logic sec_gnt_out,
    output logic sec_stall_out,
    output logic sec_err_out,
    output logic [NB:0] tgt_sel_out,
    output logic [NB:0] tgt_owner_out,
    output logic sec_rst_n_out,
    output logic sec_clk_en_out,
    output logic sec_run_out,
    output logic sec_sleep_out,
    output logic [31:0] sec_boot_out,
    output logic [31:0] sec_stack_out,
    output logic lp_req_out,
    output logic irq_to_pri_out,
    output logic irq_to_sec_out,
    output logic core0_primary_out
);
    dcci_pkg::dcci_sec_st_t st, next_st;
    logic hold, next_hold, dis, next_dis;
    logic [31:0] boot, next_boot, stack, next_stack;
    logic boot_set, next_boot_set, stack_set, next_stack_set;
    logic prio_sec, next_prio_sec;
    logic [NB-1:0] bank_pwr, next_bank_pwr;
    logic [31:0] mb_to_sec, next_mb_to_sec, mb_to_pri, next_mb_to_pri;
    logic mtx_lock, next_mtx_lock, mtx_own, next_mtx_own;
    logic lp_ign, next_lp_ign, next_lp_req;
    logic [31:0] next_rdata, next_boot_o, next_stack_o;
    logic next_pg, next_ps, next_pe, next_sg, next_ss, next_se;
    logic [NB:0] next_sel, next_own;
    logic wr_pri, wr_sec, is_pri, pv, sv, pa, sa, cf;

    assign is_pri = (reg_src_in == `DCCI_SRC_PRI);
    assign wr_pri = reg_wr_in && is_pri;
    assign wr_sec = reg_wr_in && !is_pri;

    function automatic logic pwr_ok(input logic [TW-1:0] t,
                                    input logic [NB-1:0] p);
        logic ok;
        ok = (t == '0);
        for (int i = 0; i < NB; i++)
        begin
            if (t == TW'(i + 1))
                ok = p[i];
        end
        return ok;
    endfunction

    always_comb
    begin
        next_st = st;
        next_hold = hold;
        next_dis = dis;
        next_boot = boot;
        next_stack = stack;
        next_boot_set = boot_set;
        next_stack_set = stack_set;
        next_prio_sec = prio_sec;
        next_bank_pwr = bank_pwr;
        next_mb_to_sec = mb_to_sec;
        next_mb_to_pri = mb_to_pri;
        next_mtx_lock = mtx_lock;
        next_mtx_own = mtx_own;
        next_lp_ign = lp_ign;
        next_lp_req = 1'b0;
        next_rdata = 32'h00000000;
        next_boot_o = sec_boot_out;
        next_stack_o = sec_stack_out;
        if (wr_pri)
        begin
            if (reg_addr_in == `DCCI_CTRL)
            begin
                next_hold = reg_wdata_in[`DCCI_CTRL_HOLD];
                next_dis = reg_wdata_in[`DCCI_CTRL_DIS];
            end
            else if (reg_addr_in == `DCCI_BOOT)
            begin
                next_boot = reg_wdata_in;
                next_boot_set = 1'b1;
            end
            else if (reg_addr_in == `DCCI_STACK)
            begin
                next_stack = reg_wdata_in;
                next_stack_set = 1'b1;
            end
            else if (reg_addr_in == `DCCI_PRIO)
                next_prio_sec = reg_wdata_in[0];
            else if (reg_addr_in == `DCCI_BANKPWR)
                next_bank_pwr = reg_wdata_in[NB-1:0];
        end
        if (reg_wr_in && reg_addr_in == `DCCI_PWR &&
            reg_wdata_in[`DCCI_PWR_LP])
        begin
            if (is_pri)
                next_lp_req = 1'b1;
            else
                next_lp_ign = 1'b1;
        end
        else if (wr_pri && reg_addr_in == `DCCI_STATUS &&
                 reg_wdata_in[`DCCI_ST_LPIGN])
            next_lp_ign = 1'b0;
        if (wr_sec && reg_addr_in == `DCCI_MB_TO_SEC)
            next_mb_to_sec = mb_to_sec & ~reg_wdata_in;
        if (wr_pri && reg_addr_in == `DCCI_MB_TO_SEC)
            next_mb_to_sec = next_mb_to_sec | reg_wdata_in;
        if (wr_pri && reg_addr_in == `DCCI_MB_TO_PRI)
            next_mb_to_pri = mb_to_pri & ~reg_wdata_in;
        if (wr_sec && reg_addr_in == `DCCI_MB_TO_PRI)
            next_mb_to_pri = next_mb_to_pri | reg_wdata_in;
        // owner releases with bit 0 low
        if (reg_wr_in && reg_addr_in == `DCCI_MUTEX && mtx_lock &&
            mtx_own == reg_src_in && !reg_wdata_in[0])
            next_mtx_lock = 1'b0;
        if (reg_rd_in)
        begin
            if (reg_addr_in == `DCCI_CTRL)
            begin
                next_rdata[`DCCI_CTRL_HOLD] = hold;
                next_rdata[`DCCI_CTRL_DIS] = dis;
            end
            else if (reg_addr_in == `DCCI_BOOT)
                next_rdata = boot;
            else if (reg_addr_in == `DCCI_STACK)
                next_rdata = stack;
            else if (reg_addr_in == `DCCI_PRIO)
                next_rdata[0] = prio_sec;
            else if (reg_addr_in == `DCCI_BANKPWR)
                next_rdata[NB-1:0] = bank_pwr;
            else if (reg_addr_in == `DCCI_MB_TO_SEC)
                next_rdata = mb_to_sec;
            else if (reg_addr_in == `DCCI_MB_TO_PRI)
                next_rdata = mb_to_pri;
            else if (reg_addr_in == `DCCI_MUTEX)
            begin
                next_rdata[0] = !mtx_lock;
                if (!mtx_lock)
                begin
                    next_mtx_lock = 1'b1;
                    next_mtx_own = reg_src_in;
                end
            end
            else if (reg_addr_in == `DCCI_STATUS)
            begin
                next_rdata[`DCCI_ST_SLEEP] = (st == dcci_pkg::SEC_SLEEP);
                next_rdata[`DCCI_ST_RUN] = (st == dcci_pkg::SEC_RUN);
                next_rdata[`DCCI_ST_LPIGN] = lp_ign;
                next_rdata[`DCCI_ST_MLOCK] = mtx_lock;
                next_rdata[`DCCI_ST_MOWN] = mtx_own;
            end
        end
        case (st)
            dcci_pkg::SEC_HELD:
            begin
                if (!hold && boot_set && stack_set)
                begin
                    next_st = dcci_pkg::SEC_RUN;
                    next_boot_o = boot;
                    next_stack_o = stack;
                end
                else if (!hold)
                    next_st = dcci_pkg::SEC_SLEEP;
            end
            default:
                if (hold)
                    next_st = dcci_pkg::SEC_HELD;
        endcase
    end

    // Per-target arbitration
    always_comb
    begin
        pv = pri_req_in;
        sv = sec_req_in && st == dcci_pkg::SEC_RUN && !dis;
        // code buses limited to flash, coupled bank
        next_pe = pv && (pri_tgt_in > TW'(NB) ||
            !pwr_ok(pri_tgt_in, bank_pwr) ||
            (LATE_VARIANT && pri_bus_in != dcci_pkg::BUS_SYS &&
             pri_tgt_in > TW'(1)));
        next_se = sv && (sec_tgt_in > TW'(NB) ||
            !pwr_ok(sec_tgt_in, bank_pwr));
        pa = pv && !next_pe;
        sa = sv && !next_se;
        cf = pa && sa && pri_tgt_in == sec_tgt_in;
        next_sel = '0;
        next_own = '0;
        for (int t = 0; t <= NB; t++)
        begin
            if (pa && pri_tgt_in == TW'(t) && !(cf && prio_sec))
                next_sel[t] = 1'b1;
            else if (sa && sec_tgt_in == TW'(t))
            begin
                next_sel[t] = 1'b1;
                next_own[t] = 1'b1;
            end
        end
        next_pg = pa && !(cf && prio_sec);
        next_sg = sa && !(cf && !prio_sec);
        next_ps = pa && !next_pg;
        next_ss = sa && !next_sg;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            st <= dcci_pkg::SEC_HELD;
            hold <= 1'b0;
            dis <= 1'b0;
            boot <= `DCCI_VEC_RST;
            stack <= `DCCI_VEC_RST;
            boot_set <= 1'b0;
            stack_set <= 1'b0;
            prio_sec <= 1'b0;
            bank_pwr <= '1;
            mb_to_sec <= 32'h00000000;
            mb_to_pri <= 32'h00000000;
            mtx_lock <= 1'b0;
            mtx_own <= 1'b0;
            lp_ign <= 1'b0;
            lp_req_out <= 1'b0;
            reg_rdata_out <= 32'h00000000;
            sec_boot_out <= `DCCI_VEC_RST;
            sec_stack_out <= `DCCI_VEC_RST;
            sec_rst_n_out <= 1'b0;
            sec_clk_en_out <= 1'b0;
            sec_run_out <= 1'b0;
            sec_sleep_out <= 1'b0;
            irq_to_pri_out <= 1'b0;
            irq_to_sec_out <= 1'b0;
            core0_primary_out <= 1'b0;
            pri_gnt_out <= 1'b0;
            pri_stall_out <= 1'b0;
            pri_err_out <= 1'b0;
            sec_gnt_out <= 1'b0;
            sec_stall_out <= 1'b0;
            sec_err_out <= 1'b0;
            tgt_sel_out <= '0;
            tgt_owner_out <= '0;
        end
        else
        begin
            st <= next_st;
            hold <= next_hold;
            dis <= next_dis;
            boot <= next_boot;
            stack <= next_stack;
            boot_set <= next_boot_set;
            stack_set <= next_stack_set;
            prio_sec <= next_prio_sec;
            bank_pwr <= next_bank_pwr;
            mb_to_sec <= next_mb_to_sec;
            mb_to_pri <= next_mb_to_pri;
            mtx_lock <= next_mtx_lock;
            mtx_own <= next_mtx_own;
            lp_ign <= next_lp_ign;
            lp_req_out <= next_lp_req;
            reg_rdata_out <= next_rdata;
            sec_boot_out <= next_boot_o;
            sec_stack_out <= next_stack_o;
            sec_rst_n_out <= (next_st != dcci_pkg::SEC_HELD);
            sec_clk_en_out <= !next_dis;
            sec_run_out <= (next_st == dcci_pkg::SEC_RUN);
            sec_sleep_out <= (next_st == dcci_pkg::SEC_SLEEP);
            irq_to_pri_out <= |next_mb_to_pri;
            irq_to_sec_out <= |next_mb_to_sec;
            core0_primary_out <= 1'b1;
            pri_gnt_out <= next_pg;
            pri_stall_out <= next_ps;
            pri_err_out <= next_pe;
            sec_gnt_out <= next_sg;
            sec_stall_out <= next_ss;
            sec_err_out <= next_se;
            tgt_sel_out <= next_sel;
            tgt_owner_out <= next_own;
        end
    end
endmodule // dcci_top
`default_nettype wire

// [tb/dcci_checker.sv]
// Purpose: Port-level assertions for dcci_top
// Assumes: Single clock, synchronous active-low reset
// Notes: Bound to every dcci_top instance
`include "dcci_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dcci_checker #(
    parameter int NB = 4,
    parameter int TW = 3,
    parameter bit LATE_VARIANT = 1'b1
)(
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic reg_src_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic pri_req_in,
    input wire logic [1:0] pri_bus_in,
    input wire logic [TW-1:0] pri_tgt_in,
    input wire logic sec_req_in,
    input wire logic [TW-1:0] sec_tgt_in,
    input wire logic pri_gnt_out,
    input wire logic pri_stall_out,
    input wire logic pri_err_out,
    input wire logic sec_gnt_out,
    input wire logic sec_stall_out,
    input wire logic [NB:0] tgt_sel_out,
    input wire logic [NB:0] tgt_owner_out,
    input wire logic sec_rst_n_out,
    input wire logic lp_req_out,
    input wire logic irq_to_sec_out,
    input wire logic core0_primary_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_same_bank;
        pri_req_in && sec_req_in && pri_tgt_in == sec_tgt_in;
    endsequence
    sequence s_split_banks;
        pri_req_in && sec_req_in && pri_tgt_in != sec_tgt_in;
    endsequence
    a_same_bank_one: assert property (s_same_bank |=>
        !(pri_gnt_out && sec_gnt_out)) else $error("both cores granted");
    a_stall_has_cause: assert property (pri_stall_out || sec_stall_out |->
        $past(pri_req_in && sec_req_in && pri_tgt_in == sec_tgt_in))
        else $error("stall without conflict");
    a_split_no_stall: assert property (s_split_banks |=>
        !pri_stall_out && !sec_stall_out) else $error("split banks stalled");
    a_code_bus_err: assert property (LATE_VARIANT && pri_req_in &&
        pri_bus_in != 2'h2 && pri_tgt_in >= 2 |=> pri_err_out && !pri_gnt_out)
        else $error("code bus reached system bank");
    a_lp_primary: assert property (lp_req_out |-> $past(reg_wr_in &&
        !reg_src_in && reg_addr_in == `DCCI_PWR && reg_wdata_in[0]))
        else $error("low-power pulse without primary request");
    a_hold_primary: assert property ($fell(sec_rst_n_out) |->
        $past(reg_wr_in && !reg_src_in && reg_addr_in == `DCCI_CTRL, 2))
        else $error("secondary reset without primary write");
    a_grant_path: assert property (pri_gnt_out |->
        tgt_sel_out[$past(pri_tgt_in)] && !tgt_owner_out[$past(pri_tgt_in)])
        else $error("primary grant without its target path");
    a_sec_owner: assert property (sec_gnt_out |->
        tgt_sel_out[$past(sec_tgt_in)] && tgt_owner_out[$past(sec_tgt_in)])
        else $error("secondary grant not owned");
    a_primary_role: assert property (nrst_in && $past(nrst_in) |->
        core0_primary_out) else $error("core0 not primary");
    a_mbox_raise: assert property ($rose(irq_to_sec_out) |->
        $past(reg_wr_in && !reg_src_in && reg_addr_in == `DCCI_MB_TO_SEC))
        else $error("mailbox irq without primary write");
    a_rdata_idle: assert property (!$past(reg_rd_in) |->
        reg_rdata_out == 32'h0) else $error("read data outside slot");
endmodule // dcci_checker
bind dcci_top dcci_checker #(.NB(NB), .TW(TW),
    .LATE_VARIANT(LATE_VARIANT)) chk_i (.*);
`default_nettype wire

// [tb/dcci_core_model.sv]
// Purpose: One bus-master core issuing a bank access
// Assumes: go_in is a one-cycle pulse
// Notes: res_out 1 granted, 2 refused, 3 granted after stall
`timescale 1ns/1ps
`default_nettype none
module dcci_core_model (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic go_in,
    input wire logic [2:0] tgt_in,
    input wire logic gnt_in,
    input wire logic stall_in,
    input wire logic err_in,
    output logic req_out,
    output logic [2:0] tgt_out,
    output logic [1:0] res_out
);
    logic stalled;
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in || go_in)
        begin
            req_out <= go_in;
            tgt_out <= tgt_in;
            res_out <= 2'h0;
            stalled <= 1'b0;
        end
        else
        begin
            req_out <= stall_in;
            if (stall_in)
                stalled <= 1'b1;
            if (gnt_in)
                res_out <= stalled ? 2'h3 : 2'h1;
            if (err_in)
                res_out <= 2'h2;
        end
    end
endmodule // dcci_core_model
`default_nettype wire

// [tb/test_dcci_top.sv]
// Purpose: Self-checking bench for dcci_top
// Assumes: Two core models drive the bank port
// Notes: Secondary is booted before bank traffic
`include "dcci_map.svh"
`timescale 1ns/1ps
`default_nettype none
module test_dcci_top;
    logic core_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, reg_src_in = 1'b0, go = 1'b0;
    logic [1:0] pri_bus_in = 2'h2, pres, sres;
    logic [2:0] ptgt = 3'h0, stgt = 3'h0, pri_tgt_in, sec_tgt_in;
    logic [31:0] reg_rdata_out, sec_boot_out, sec_stack_out, rdat;
    logic pri_req_in, sec_req_in, pri_gnt_out, pri_stall_out, pri_err_out;
    logic sec_gnt_out, sec_stall_out, sec_err_out, sec_rst_n_out;
    logic sec_clk_en_out, sec_run_out, sec_sleep_out, lp_req_out;
    logic irq_to_pri_out, irq_to_sec_out, core0_primary_out;
    logic [4:0] tgt_sel_out, tgt_owner_out;
    int miscompares = 0, n_tests = 0;
    always #4 core_clk_in = ~core_clk_in;
    dcci_top uut (.*);
    dcci_core_model pri_m (.clk_in(core_clk_in), .nrst_in(nrst_in),
        .go_in(go), .tgt_in(ptgt), .gnt_in(pri_gnt_out),
        .stall_in(pri_stall_out), .err_in(pri_err_out),
        .req_out(pri_req_in), .tgt_out(pri_tgt_in), .res_out(pres));
    dcci_core_model sec_m (.clk_in(core_clk_in), .nrst_in(nrst_in),
        .go_in(go), .tgt_in(stgt), .gnt_in(sec_gnt_out),
        .stall_in(sec_stall_out), .err_in(sec_err_out),
        .req_out(sec_req_in), .tgt_out(sec_tgt_in), .res_out(sres));
    task print_verdict;
        if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic s);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_src_in <= s;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, input logic s);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_src_in <= s;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 rdat = reg_rdata_out;
    endtask
    task bank(input logic [1:0] pb, input logic [2:0] pt, input logic [2:0] st);
        int i;
        @(posedge core_clk_in);
        pri_bus_in <= pb;
        ptgt <= pt;
        stgt <= st;
        go <= 1'b1;
        @(posedge core_clk_in);
        go <= 1'b0;
        #1;
        for (i = 0; i < 20 && (pres == 2'h0 || sres == 2'h0); i++)
        begin
            @(posedge core_clk_in);
            #1;
        end
        if (i == 20)
        begin
            miscompares++;
            print_verdict;
        end
    endtask
    task t_boot;
        chk({31'h0, core0_primary_out}, 32'h1);
        chk({31'h0, sec_sleep_out}, 32'h1);
        wr(`DCCI_CTRL, 32'h1, 1'b0);
        wr(`DCCI_CTRL, 32'h0, 1'b1);
        chk({31'h0, sec_rst_n_out}, 32'h0);
        wr(`DCCI_BOOT, 32'h0000_2000, 1'b0);
        wr(`DCCI_STACK, 32'h0000_3f00, 1'b0);
        wr(`DCCI_BOOT, 32'h0000_0bad, 1'b1);
        wr(`DCCI_CTRL, 32'h0, 1'b0);
        repeat (3) @(posedge core_clk_in);
        #1;
        chk({31'h0, sec_run_out}, 32'h1);
        chk(sec_boot_out, 32'h0000_2000);
        chk(sec_stack_out, 32'h0000_3f00);
        wr(`DCCI_CTRL, 32'h2, 1'b0);
        wr(`DCCI_CTRL, 32'h0, 1'b1);
        chk({31'h0, sec_clk_en_out}, 32'h0);
        wr(`DCCI_CTRL, 32'h0, 1'b0);
        chk({31'h0, sec_clk_en_out}, 32'h1);
    endtask
    task t_lp_mbox;
        wr(`DCCI_PWR, 32'h1, 1'b0);
        chk({31'h0, lp_req_out}, 32'h1);
        wr(`DCCI_PWR, 32'h1, 1'b1);
        chk({31'h0, lp_req_out}, 32'h0);
        rd(`DCCI_STATUS, 1'b0);
        chk({31'h0, rdat[2]}, 32'h1);
        wr(`DCCI_STATUS, 32'h4, 1'b0);
        rd(`DCCI_STATUS, 1'b0);
        chk({31'h0, rdat[2]}, 32'h0);
        wr(`DCCI_MB_TO_SEC, 32'h5, 1'b0);
        chk({31'h0, irq_to_sec_out}, 32'h1);
        wr(`DCCI_MB_TO_SEC, 32'h5, 1'b1);
        chk({31'h0, irq_to_sec_out}, 32'h0);
        wr(`DCCI_MB_TO_PRI, 32'h1, 1'b1);
        chk({31'h0, irq_to_pri_out}, 32'h1);
        wr(`DCCI_MB_TO_PRI, 32'h1, 1'b0);
        chk({31'h0, irq_to_pri_out}, 32'h0);
    endtask
    task t_mutex;
        rd(`DCCI_MUTEX, 1'b0);
        chk({31'h0, rdat[0]}, 32'h1);
        rd(`DCCI_MUTEX, 1'b1);
        chk({31'h0, rdat[0]}, 32'h0);
        wr(`DCCI_MUTEX, 32'h0, 1'b0);
        rd(`DCCI_MUTEX, 1'b1);
        chk({31'h0, rdat[0]}, 32'h1);
        rd(8'h3c, 1'b0);
        chk(rdat, 32'h0);
    endtask
    task t_banks;
        bank(2'h2, 3'h2, 3'h3);
        chk({28'h0, pres, sres}, 32'h5);
        bank(2'h2, 3'h2, 3'h2);
        chk({28'h0, pres, sres}, 32'h7);
        wr(`DCCI_PRIO, 32'h1, 1'b0);
        bank(2'h2, 3'h4, 3'h4);
        chk({28'h0, pres, sres}, 32'hd);
        bank(2'h0, 3'h3, 3'h4);
        chk({28'h0, pres, sres}, 32'h9);
        bank(2'h0, 3'h0, 3'h1);
        chk({28'h0, pres, sres}, 32'h5);
        wr(`DCCI_BANKPWR, 32'h7, 1'b0);
        bank(2'h1, 3'h1, 3'h4);
        chk({28'h0, pres, sres}, 32'h6);
    endtask
    initial
    begin
        repeat (10) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        #1;
        t_boot;
        t_lp_mbox;
        t_mutex;
        t_banks;
        print_verdict;
    end
endmodule // test_dcci_top
`default_nettype wire
